// file: design/uart_frame_consts.vh
`ifndef UART_FRAME_CONSTS_VH
`define UART_FRAME_CONSTS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_FMT      3'h0
`define OFS_CTRL     3'h1
`define OFS_TXDATA   3'h2
`define OFS_RXDATA   3'h3
`define OFS_STATUS   3'h4
`define OFS_BAUD     3'h5

// ------------------------------------------------------------
// Format register fields
// ------------------------------------------------------------
`define FMT_PTYPE    0
`define FMT_PEN      1
`define FMT_ILT      2
`define FMT_WAKE     3
`define FMT_LEN9     4
`define FMT_RESET    8'h00

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CTL_RWU      0
`define CTL_M10      1
`define CTL_SCEN     2
`define CTL_TXEN     3
`define CTL_RXEN     4
`define CTL_RESET    8'h00

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define ST_RXFULL    0
`define ST_PERR      1
`define ST_IDLE      2
`define ST_TXFULL    3
`define ST_TXBUSY    4
`define ST_RXBUSY    5
`define ST_TXEMPTY   6

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define BAUD_RESET   16'h015B

`endif

// file: design/uart_frame.v
`timescale 1ns/100ps
`default_nettype none
`include "uart_frame_consts.vh"

// ------------------------------------------------------------
// Transmit FIFO
// ------------------------------------------------------------
module frame_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rstn_i,
    // Fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    // Sized copy of the depth; a part-select of a parameter is not portable
    localparam [AW:0] FULL = DEPTH;

    reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg  [AW-1:0]    wp_reg;
    reg  [AW-1:0]    rp_reg;
    reg  [AW:0]      cnt_reg;
    wire             push;
    wire             pop;

    assign in_ready_o  = (cnt_reg != FULL);
    assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem_reg[rp_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : entry
            localparam [AW-1:0] IDX = g;
            always @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i)
                    mem_reg[g] <= {WIDTH{1'b0}};
                else if (push && wp_reg == IDX)
                    mem_reg[g] <= in_data_i;
            end
        end
    endgenerate

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_reg  <= {AW{1'b0}};
            rp_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wp_reg <= wp_reg + 1'b1;
            if (pop)
                rp_reg <= rp_reg + 1'b1;
            if (push && !pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule // frame_fifo

// ------------------------------------------------------------
// Frame format transceiver
// ------------------------------------------------------------
module uart_frame (
    // Clock and reset
    input  wire        REF_CLK_I,
    input  wire        RSTN_I,
    // Register port
    input  wire [2:0]  ADDR_I,
    input  wire [15:0] WDATA_I,
    input  wire        WR_I,
    input  wire        RD_I,
    output reg  [15:0] RDATA_O,
    // Serial line
    input  wire        RXD_I,
    output reg         TXD_O
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_DATA  = 2'd2;
    localparam ST_STOP  = 2'd3;

    reg  [7:0]  fmt_reg;
    reg  [7:0]  ctl_reg;
    reg  [15:0] baud_reg;
    reg         rx_full_reg;
    reg         perr_reg;
    reg         idle_reg;
    reg  [9:0]  rx_data_reg;
    reg  [1:0]  rx_st_reg;
    reg  [15:0] rx_tmr_reg;
    reg  [3:0]  rx_idx_reg;
    reg  [9:0]  rx_sh_reg;
    reg         rx_par_reg;
    reg         rx_perr_reg;
    reg  [3:0]  idle_cnt_reg;
    reg  [3:0]  idle_cnt_next;
    reg  [1:0]  tx_st_reg;
    reg  [15:0] tx_tmr_reg;
    reg  [3:0]  tx_idx_reg;
    reg  [9:0]  tx_sh_reg;
    reg         tx_par_reg;
    reg  [15:0] rd_next;

    wire        len9     = fmt_reg[`FMT_LEN9];
    wire        pen      = fmt_reg[`FMT_PEN];
    wire        ptype    = fmt_reg[`FMT_PTYPE];
    wire        receiver_wakeup_ctrl      = ctl_reg[`CTL_RWU];
    // Tenth slot exists only with nine data bits and parity on
    wire        ten      = ctl_reg[`CTL_M10] & len9 & pen;
    wire [3:0]  n_slots  = 4'd8 + {3'd0, len9} + {3'd0, ten};
    wire [3:0]  n_data   = n_slots - {3'd0, pen};
    wire [3:0]  idle_thr = n_slots + 4'd2;
    wire        wake_idl = receiver_wakeup_ctrl & ~fmt_reg[`FMT_WAKE];
    wire        ilt_eff  = fmt_reg[`FMT_ILT] & ~wake_idl;
    wire [15:0] half     = {1'b0, baud_reg[15:1]};
    wire        rx_tick  = (rx_tmr_reg == 16'h0000);
    wire        tx_tick  = (tx_tmr_reg == 16'h0000);
    wire        rx_last  = (rx_idx_reg == n_slots - 4'd1);
    wire        tx_last  = (tx_idx_reg == n_slots - 4'd1);
    wire [3:0]  tx_nx    = tx_idx_reg + 4'd1;
    wire [3:0]  cnt_inc  = (idle_cnt_reg == 4'hF) ? idle_cnt_reg : idle_cnt_reg + 4'd1;
    wire        idle_evt = (idle_cnt_next == idle_thr) && (idle_cnt_reg != idle_thr);
    wire        rx_en    = ctl_reg[`CTL_RXEN];
    wire        wr_tx    = WR_I && ADDR_I == `OFS_TXDATA;
    wire        rd_rx    = RD_I && ADDR_I == `OFS_RXDATA;
    wire        fifo_rdy;
    wire        fifo_vld;
    wire [9:0]  fifo_dat;
    wire        tx_pop   = (tx_st_reg == ST_IDLE) & ctl_reg[`CTL_TXEN];
    wire [9:0]  dmask    = ~(10'h3FF << n_data);
    wire        addr_hit = rx_sh_reg[n_data - 4'd1];
    wire        deliver  = (rx_st_reg == ST_STOP) && rx_tick && rx_en && (!receiver_wakeup_ctrl || (fmt_reg[`FMT_WAKE] && addr_hit));

    // Writes to a full FIFO are dropped; software polls the full flag
    frame_fifo #(.WIDTH(10), .DEPTH(8), .AW(3)) u_txq (
        .clk_i       (REF_CLK_I),
        .rstn_i      (RSTN_I),
        .in_valid_i  (wr_tx),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (WDATA_I[9:0]),
        .out_valid_o (fifo_vld),
        .out_ready_i (tx_pop),
        .out_data_o  (fifo_dat)
    );

    // ------------------------------------------------------------
    // Idle counter
    // ------------------------------------------------------------
    always @* begin
        idle_cnt_next = idle_cnt_reg;
        if (rx_tick && rx_en) begin
            case (rx_st_reg)
                ST_IDLE:  idle_cnt_next = RXD_I ? cnt_inc : 4'd0;
                ST_START: idle_cnt_next = 4'd0;
                ST_DATA:  idle_cnt_next = (ilt_eff || !RXD_I) ? 4'd0 : cnt_inc;
                ST_STOP:  idle_cnt_next = (ilt_eff || !RXD_I) ? 4'd0 : cnt_inc;
                default:  idle_cnt_next = 4'd0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers and status
    // ------------------------------------------------------------
    always @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            fmt_reg     <= `FMT_RESET;
            ctl_reg     <= `CTL_RESET;
            baud_reg    <= `BAUD_RESET;
            rx_full_reg <= 1'b0;
            perr_reg    <= 1'b0;
            idle_reg    <= 1'b0;
            rx_data_reg <= 10'h000;
        end else begin
            if (WR_I && ADDR_I == `OFS_FMT)
                fmt_reg <= WDATA_I[7:0];
            if (WR_I && ADDR_I == `OFS_BAUD)
                baud_reg <= WDATA_I;
            // Wakeup clears the bit; a software write in the same cycle wins
            if (idle_evt && wake_idl)
                ctl_reg[`CTL_RWU] <= 1'b0;
            else if (deliver && receiver_wakeup_ctrl)
                ctl_reg[`CTL_RWU] <= 1'b0;
            if (WR_I && ADDR_I == `OFS_CTRL)
                ctl_reg <= WDATA_I[7:0];
            // Write one to clear; a new event in the same cycle wins
            if (WR_I && ADDR_I == `OFS_STATUS && WDATA_I[`ST_PERR])
                perr_reg <= 1'b0;
            if (WR_I && ADDR_I == `OFS_STATUS && WDATA_I[`ST_IDLE])
                idle_reg <= 1'b0;
            if (rd_rx)
                rx_full_reg <= 1'b0;
            if (idle_evt)
                idle_reg <= 1'b1;
            if (deliver) begin
                rx_data_reg <= rx_sh_reg & dmask;
                rx_full_reg <= 1'b1;
                if (rx_perr_reg)
                    perr_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    always @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rx_st_reg    <= ST_IDLE;
            rx_tmr_reg   <= 16'h0000;
            rx_idx_reg   <= 4'd0;
            rx_sh_reg    <= 10'h000;
            rx_par_reg   <= 1'b0;
            rx_perr_reg  <= 1'b0;
            idle_cnt_reg <= 4'd0;
        end else begin
            idle_cnt_reg <= idle_cnt_next;
            if (!rx_tick)
                rx_tmr_reg <= rx_tmr_reg - 16'h0001;
            if (!rx_en) begin
                rx_st_reg <= ST_IDLE;
            end else begin
                case (rx_st_reg)
                    ST_IDLE: begin
                        if (!RXD_I) begin
                            rx_st_reg  <= ST_START;
                            rx_tmr_reg <= half;
                        end else if (rx_tick) begin
                            rx_tmr_reg <= baud_reg - 16'h0001;
                        end
                    end
                    ST_START: begin
                        if (rx_tick) begin
                            // A high mid-start is a glitch, not a frame
                            rx_st_reg   <= RXD_I ? ST_IDLE : ST_DATA;
                            rx_tmr_reg  <= baud_reg - 16'h0001;
                            rx_idx_reg  <= 4'd0;
                            rx_par_reg  <= 1'b0;
                            rx_perr_reg <= 1'b0;
                        end
                    end
                    ST_DATA: begin
                        if (rx_tick) begin
                            rx_tmr_reg            <= baud_reg - 16'h0001;
                            rx_sh_reg[rx_idx_reg] <= RXD_I;
                            rx_idx_reg            <= rx_idx_reg + 4'd1;
                            if (rx_idx_reg < n_data)
                                rx_par_reg <= rx_par_reg ^ RXD_I;
                            else if (RXD_I != (rx_par_reg ^ ptype))
                                rx_perr_reg <= 1'b1;
                            if (rx_last)
                                rx_st_reg <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        if (rx_tick) begin
                            rx_st_reg  <= ST_IDLE;
                            rx_tmr_reg <= baud_reg - 16'h0001;
                        end
                    end
                    default: rx_st_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    always @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tx_st_reg  <= ST_IDLE;
            tx_tmr_reg <= 16'h0000;
            tx_idx_reg <= 4'd0;
            tx_sh_reg  <= 10'h000;
            tx_par_reg <= 1'b0;
            TXD_O      <= 1'b1;
        end else begin
            if (!tx_tick)
                tx_tmr_reg <= tx_tmr_reg - 16'h0001;
            case (tx_st_reg)
                ST_IDLE: begin
                    TXD_O <= 1'b1;
                    if (tx_pop && fifo_vld) begin
                        tx_sh_reg  <= fifo_dat;
                        tx_st_reg  <= ST_START;
                        tx_tmr_reg <= baud_reg - 16'h0001;
                        TXD_O      <= 1'b0;
                    end
                end
                ST_START: begin
                    if (tx_tick) begin
                        tx_st_reg  <= ST_DATA;
                        tx_idx_reg <= 4'd0;
                        tx_tmr_reg <= baud_reg - 16'h0001;
                        TXD_O      <= tx_sh_reg[0];
                        tx_par_reg <= tx_sh_reg[0];
                    end
                end
                ST_DATA: begin
                    if (tx_tick) begin
                        tx_tmr_reg <= baud_reg - 16'h0001;
                        tx_idx_reg <= tx_nx;
                        if (tx_last) begin
                            tx_st_reg <= ST_STOP;
                            TXD_O     <= 1'b1;
                        end else if (pen && tx_nx == n_slots - 4'd1) begin
                            TXD_O <= tx_par_reg ^ ptype;
                        end else begin
                            TXD_O      <= tx_sh_reg[tx_nx];
                            tx_par_reg <= tx_par_reg ^ tx_sh_reg[tx_nx];
                        end
                    end
                end
                ST_STOP: begin
                    if (tx_tick)
                        tx_st_reg <= ST_IDLE;
                end
                default: tx_st_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always @* begin
        rd_next = 16'h0000;
        case (ADDR_I)
            `OFS_FMT:    rd_next = {8'h00, fmt_reg};
            `OFS_CTRL:   rd_next = {8'h00, ctl_reg};
            `OFS_RXDATA: rd_next = {6'h00, rx_data_reg};
            `OFS_STATUS: rd_next = {9'h000, !fifo_vld, rx_st_reg != ST_IDLE, tx_st_reg != ST_IDLE,
                                    !fifo_rdy, idle_reg, perr_reg, rx_full_reg};
            `OFS_BAUD:   rd_next = baud_reg;
            default:     rd_next = 16'h0000;
        endcase
    end

    always @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I)
            RDATA_O <= 16'h0000;
        else
            RDATA_O <= RD_I ? rd_next : 16'h0000;
    end
endmodule // uart_frame
`default_nettype wire

// file: dv/uart_frame_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "uart_frame_consts.vh"
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module uart_frame_props (
    input wire logic        REF_CLK_I,
    input wire logic        RSTN_I,
    input wire logic [2:0]  ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic        RXD_I,
    input wire logic        TXD_O
);
    logic [15:0] baud_reg;
    logic [15:0] low_reg;
    default clocking dc @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);
    // Low run of the line, held against the bit period
    always @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            baud_reg <= `BAUD_RESET;
            low_reg  <= 16'h0000;
        end else begin
            if (WR_I && ADDR_I == `OFS_BAUD) baud_reg <= WDATA_I;
            low_reg <= TXD_O ? 16'h0000 : low_reg + 16'h0001;
        end
    end
    property p_rd_only; !$past(RD_I) |-> RDATA_O == 16'h0000; endproperty
    a_rd_only: assert property (p_rd_only) else $error("read data outside its slot");
    property p_unmapped; RD_I && ADDR_I > `OFS_BAUD |=> RDATA_O == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_tx_rd0; RD_I && ADDR_I == `OFS_TXDATA |=> RDATA_O == 16'h0000; endproperty
    a_tx_rd0: assert property (p_tx_rd0) else $error("transmit data read not zero");
    property p_fmt_back;
        WR_I && ADDR_I == `OFS_FMT ##1 RD_I && ADDR_I == `OFS_FMT
        |=> ((RDATA_O ^ $past(WDATA_I, 2)) & 16'h001F) == 16'h0000;
    endproperty
    a_fmt_back: assert property (p_fmt_back) else $error("format readback differs");
    property p_baud_back;
        WR_I && ADDR_I == `OFS_BAUD ##1 RD_I && ADDR_I == `OFS_BAUD |=> RDATA_O == $past(WDATA_I, 2);
    endproperty
    a_baud_back: assert property (p_baud_back) else $error("bit period readback differs");
    property p_fifo_flags;
        RD_I && ADDR_I == `OFS_STATUS |=> !(RDATA_O[`ST_TXFULL] && RDATA_O[`ST_TXEMPTY]);
    endproperty
    a_fifo_flags: assert property (p_fifo_flags) else $error("fifo full and empty together");
    property p_rx_width; RD_I && ADDR_I == `OFS_RXDATA |=> RDATA_O[15:10] == 6'h00; endproperty
    a_rx_width: assert property (p_rx_width) else $error("receive data too wide");
    property p_bit_grid;
        $rose(TXD_O) |-> low_reg != 16'h0000 && (low_reg % baud_reg) == 16'h0000;
    endproperty
    a_bit_grid: assert property (p_bit_grid) else $error("line low run off bit grid");
    c_fmt_wr: cover property (WR_I && ADDR_I == `OFS_FMT);
    c_tx_bit: cover property ($rose(TXD_O));
    c_st_rd: cover property (RD_I && ADDR_I == `OFS_STATUS);
endmodule // uart_frame_props
bind uart_frame uart_frame_props i_props (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RXD_I(RXD_I), .TXD_O(TXD_O));
`default_nettype wire

// file: dv/serial_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Remote serial end
// ------------------------------------------------------------
module serial_peer (
    input  wire logic clk_i,
    output logic      line_o,
    input  wire logic line_i
);
    initial line_o = 1'b1;
    // Start low, slots LSB first with parity last, stop high
    task automatic send(input logic [11:0] bits, input int n, input int b);
        // Line changes only just after a rising edge
        @(posedge clk_i);
        line_o <= 1'b0;
        repeat (b) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            line_o <= bits[i];
            repeat (b) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (b) @(posedge clk_i);
    endtask
    // Samples mid-bit; bits[n] is the stop bit
    task automatic recv(output logic [11:0] bits, input int n, input int b);
        int k;
        bits = 12'h000;
        k = 0;
        while (line_i !== 1'b0 && k < 4000) begin
            @(posedge clk_i);
            k++;
        end
        repeat (b / 2) @(posedge clk_i);
        for (int i = 0; i <= n; i++) begin
            repeat (b) @(posedge clk_i);
            bits[i] = line_i;
        end
    endtask
endmodule // serial_peer
`default_nettype wire

// file: dv/tb_uart_frame.sv
`timescale 1ns/100ps
`default_nettype none
`include "uart_frame_consts.vh"
module tb_uart_frame;
    localparam int B = 8;
    logic        clk = 1'b0;
    logic        rstn;
    logic        wr;
    logic        rd;
    logic        rxd;
    logic        txd;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    int          n_fail = 0;
    int          comparisons = 0;

    always #12.5 clk = ~clk;

    uart_frame i_dut (.REF_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .RXD_I(rxd), .TXD_O(txd));
    serial_peer i_peer (.clk_i(clk), .line_o(rxd), .line_i(txd));

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr_t(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rdc(input string nm, input logic [2:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(nm, e, rdata & m);
    endtask
    // Read strobe follows the write with no gap
    task wrrd(input logic [2:0] a, input logic [15:0] d);
        wr_t(a, d);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk("readback", d, rdata);
    endtask
    task cfg(input logic [15:0] f, input logic [15:0] c);
        wrrd(`OFS_FMT, f);
        wrrd(`OFS_CTRL, c);
    endtask
    task print_verdict;
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task t_reset;
        rdc("fmt", `OFS_FMT, {8'h00, `FMT_RESET}, 16'hFFFF);
        rdc("ctrl", `OFS_CTRL, {8'h00, `CTL_RESET}, 16'hFFFF);
        rdc("baud", `OFS_BAUD, `BAUD_RESET, 16'hFFFF);
        rdc("status", `OFS_STATUS, 16'h0040, 16'h0058);
        wr_t(3'h7, 16'hFFFF);
        rdc("unmapped", 3'h7, 16'h0000, 16'hFFFF);
        wrrd(`OFS_BAUD, 16'(B));
    endtask
    // Config bits: ten-bit, nine-bit, parity on, odd
    task t_tx;
        logic [3:0]  cf [6] = '{4'b0000, 4'b0010, 4'b0011, 4'b0100, 4'b0111, 4'b1110};
        logic [11:0] got;
        logic [11:0] e;
        logic [9:0]  d;
        int          s;
        int          nd;
        foreach (cf[i]) begin
            s  = 8 + cf[i][2] + (cf[i][3] & cf[i][2] & cf[i][1]);
            nd = s - cf[i][1];
            d  = 10'h2B5 & ((10'h001 << nd) - 10'h001);
            e  = {2'b00, d};
            if (cf[i][1]) e[nd] = ^d ^ cf[i][0];
            e[s] = 1'b1;
            cfg({11'h000, cf[i][2], 2'b00, cf[i][1], cf[i][0]}, {11'h000, 2'b11, cf[i][3], cf[i][3], 1'b0});
            wr_t(`OFS_TXDATA, {6'h00, d});
            i_peer.recv(got, s, B);
            chk("tx_frame", {4'h0, e}, {4'h0, got});
        end
    endtask
    // Transmitter held off so the buffer fills and refuses
    task t_fifo;
        logic [11:0] got;
        cfg(16'h0000, 16'h0010);
        for (int i = 1; i <= 9; i++) wr_t(`OFS_TXDATA, 16'(i * 17));
        rdc("fifo_full", `OFS_STATUS, 16'h0008, 16'h0048);
        wr_t(`OFS_CTRL, 16'h0018);
        for (int i = 1; i <= 8; i++) begin
            i_peer.recv(got, 8, B);
            chk("fifo_word", 16'h0100 | 16'(i * 17), {4'h0, got});
        end
        rdc("fifo_empty", `OFS_STATUS, 16'h0040, 16'h0048);
    endtask
    task t_rx;
        logic [6:0] d;
        d = 7'h35;
        for (int t = 0; t < 2; t++) begin
            cfg(16'h0002 | 16'(t), 16'h0010);
            i_peer.send({4'h0, ^d ^ t[0], d}, 8, B);
            rdc("rx_data", `OFS_RXDATA, {9'h000, d}, 16'hFFFF);
            rdc("perr_good", `OFS_STATUS, 16'h0000, 16'h0002);
            i_peer.send({4'h0, ~(^d ^ t[0]), d}, 8, B);
            rdc("perr_bad", `OFS_STATUS, 16'h0002, 16'h0002);
            rdc("rx_bad", `OFS_RXDATA, {9'h000, d}, 16'hFFFF);
            wr_t(`OFS_STATUS, 16'h0002);
            rdc("perr_clr", `OFS_STATUS, 16'h0000, 16'h0002);
        end
    endtask
    // All-ones character; flag cleared mid-frame, read shortly and long after stop
    task t_idle(input logic [15:0] f, input logic [15:0] c, input logic [2:0] a, input logic [15:0] m,
                input logic [15:0] e1, input logic [15:0] e2);
        cfg(f, c);
        fork
            i_peer.send(12'h0FF, 8, B);
            begin
                repeat (3 * B) @(posedge clk);
                wr_t(`OFS_STATUS, 16'h0004);
            end
        join
        repeat (2 * B) @(posedge clk);
        rdc("idle_early", a, e1, m);
        repeat (10 * B) @(posedge clk);
        rdc("idle_late", a, e2, m);
    endtask

    initial begin
        rstn  = 1'b0;
        wr    = 1'b0;
        rd    = 1'b0;
        addr  = 3'h0;
        wdata = 16'h0000;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_tx;
        t_fifo;
        t_rx;
        t_idle(16'h0000, 16'h0010, `OFS_STATUS, 16'h0004, 16'h0004, 16'h0004);
        t_idle(16'h0004, 16'h0010, `OFS_STATUS, 16'h0004, 16'h0000, 16'h0004);
        t_idle(16'h0004, 16'h0011, `OFS_CTRL, 16'h0001, 16'h0000, 16'h0000);
        print_verdict;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
endmodule // tb_uart_frame
`default_nettype wire
